// >>> verilog/afc_pkg.sv
// Purpose: shared constants for the amplifier fault/clipper register slice
// Assumes: 8-bit control-port registers, 50 MHz clk
// Notes: control-port device address is arbitrary, not a real part value
package afc_pkg;
    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2A; // arbitrary value
    localparam logic [7:0] REG_RSVD_A = 8'h07;
    localparam logic [7:0] REG_FAULT = 8'h08;
    localparam logic [7:0] REG_RSVD_LO = 8'h09;
    localparam logic [7:0] REG_RSVD_HI = 8'h0F;
    localparam logic [7:0] REG_CLIP_MID = 8'h10;
    localparam logic [7:0] REG_CLIP_LOW = 8'h11;
    localparam logic [7:0] REG_CLIP_HIGH = 8'h12;
    // fault register fields
    localparam int SCALE_HI = 5;
    localparam int SCALE_LO = 4;
    localparam int BIT_CLK = 3;
    localparam int BIT_OC = 2;
    localparam int BIT_DC = 1;
    localparam int BIT_OT = 0;
    // clipper fields
    localparam int CLIP_W = 20;
    localparam int LOW_FIELD_LO = 2;
    localparam int HIGH_FIELD_W = 6;
    // reset values
    localparam logic [1:0] SCALE_RST = 2'h0;
    localparam logic [7:0] CLIP_MID_RST = 8'h01;
    localparam logic [7:0] CLIP_LOW_RST = 8'h04;
    localparam logic [7:0] CLIP_HIGH_RST = 8'h00;
    // analog interface widths and nominal overcurrent trip code
    localparam int SENSE_W = 8;
    localparam logic [7:0] OC_TRIP_NOM = 8'hC0;
    localparam int SAMPLE_W = 24;
endpackage

// >>> verilog/afc_ctrl_port.sv
// Purpose: serial control-port target, byte pointer with auto increment
// Assumes: scl and sda are pins, synchronised here on clk
// Notes: open-drain sda; sda_oe_n low means the pin is pulled low
`timescale 1ns/1ps
`default_nettype none
module afc_ctrl_port
    import afc_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic rst, // async reset
    input wire logic [6:0] dev_addr, // target address
    input wire logic scl, // serial clock pin
    input wire logic sda_i, // data pin level
    output logic sda_o, // data pin drive value
    output logic sda_oe_n, // drive enable, low drives
    output logic [7:0] ptr, // register pointer
    output logic wr_stb, // one-cycle write strobe
    output logic [7:0] wr_data, // write data
    input wire logic [7:0] rd_data // data at ptr
);
    typedef enum logic [8:0] {
        S_IDLE = 9'h001, S_ADDR = 9'h002, S_ACK_A = 9'h004,
        S_SUB = 9'h008, S_ACK_S = 9'h010, S_WDATA = 9'h020,
        S_ACK_W = 9'h040, S_RDATA = 9'h080, S_ACK_R = 9'h100
    } afc_i2c_st_t;

    logic [1:0] scl_s, sda_s;
    logic scl_q, sda_q;
    afc_i2c_st_t st, next_st;
    logic [3:0] cnt, next_cnt;
    logic [7:0] sh, next_sh, next_ptr, next_wr_data;
    logic rw, next_rw, next_oe_n, next_wr_stb, acked, next_acked;
    logic rise, fall, start, stop;

    assign rise = scl_s[1] & ~scl_q;
    assign fall = ~scl_s[1] & scl_q;
    assign start = scl_s[1] & scl_q & sda_q & ~sda_s[1];
    assign stop = scl_s[1] & scl_q & ~sda_q & sda_s[1];
    assign sda_o = 1'b0;

    always_comb begin
        next_st = st;
        next_cnt = cnt;
        next_sh = sh;
        next_ptr = ptr;
        next_rw = rw;
        next_oe_n = sda_oe_n;
        next_wr_stb = 1'b0;
        next_wr_data = wr_data;
        next_acked = acked;
        if (start) begin
            next_st = S_ADDR;
            next_cnt = 4'h0;
            next_oe_n = 1'b1;
        end else if (stop) begin
            next_st = S_IDLE;
            next_oe_n = 1'b1;
        end else begin
            case (st)
                S_ADDR, S_SUB, S_WDATA: begin
                    if (rise && cnt < 4'h8) begin
                        next_sh = {sh[6:0], sda_s[1]};
                        next_cnt = cnt + 4'h1;
                    end else if (fall && cnt == 4'h8) begin
                        next_oe_n = 1'b0;
                        if (st == S_ADDR) begin
                            next_rw = sh[0];
                            next_st = S_ACK_A;
                            if (sh[7:1] != dev_addr) begin
                                next_st = S_IDLE;
                                next_oe_n = 1'b1;
                            end
                        end else if (st == S_SUB) begin
                            next_ptr = sh;
                            next_st = S_ACK_S;
                        end else begin
                            next_wr_stb = 1'b1;
                            next_wr_data = sh;
                            next_st = S_ACK_W;
                        end
                    end
                end
                S_ACK_A, S_ACK_S, S_ACK_W: begin
                    if (fall) begin
                        next_cnt = 4'h0;
                        next_oe_n = 1'b1;
                        next_st = S_WDATA;
                        if (st == S_ACK_A && rw) begin
                            next_st = S_RDATA;
                            next_sh = rd_data;
                            next_oe_n = rd_data[7];
                        end else if (st == S_ACK_A) begin
                            next_st = S_SUB;
                        end
                        if (st == S_ACK_W) begin
                            next_ptr = ptr + 8'h01;
                        end
                    end
                end
                S_RDATA: begin
                    if (rise) begin
                        next_cnt = cnt + 4'h1;
                    end else if (fall && cnt == 4'h8) begin
                        next_oe_n = 1'b1;
                        next_st = S_ACK_R;
                    end else if (fall) begin
                        next_sh = {sh[6:0], 1'b0};
                        next_oe_n = sh[6];
                    end
                end
                S_ACK_R: begin
                    if (rise) begin
                        // a nack from the host ends the read burst
                        next_acked = ~sda_s[1];
                        if (~sda_s[1]) begin
                            next_ptr = ptr + 8'h01;
                        end
                    end else if (fall) begin
                        next_cnt = 4'h0;
                        next_st = acked ? S_RDATA : S_IDLE;
                        next_sh = rd_data;
                        next_oe_n = acked ? rd_data[7] : 1'b1;
                    end
                end
                default: begin
                    next_st = S_IDLE;
                    next_oe_n = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scl_s <= 2'h3;
            sda_s <= 2'h3;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            st <= S_IDLE;
            cnt <= 4'h0;
            sh <= 8'h00;
            ptr <= 8'h00;
            rw <= 1'b0;
            sda_oe_n <= 1'b1;
            wr_stb <= 1'b0;
            wr_data <= 8'h00;
            acked <= 1'b0;
        end else begin
            scl_s <= {scl_s[0], scl};
            sda_s <= {sda_s[0], sda_i};
            scl_q <= scl_s[1];
            sda_q <= sda_s[1];
            st <= next_st;
            cnt <= next_cnt;
            sh <= next_sh;
            ptr <= next_ptr;
            rw <= next_rw;
            sda_oe_n <= next_oe_n;
            wr_stb <= next_wr_stb;
            wr_data <= next_wr_data;
            acked <= next_acked;
        end
    end
endmodule
`default_nettype wire

// >>> verilog/afc_fault_clip.sv
// Purpose: fault configuration/status and digital clipper register slice
// Assumes: fault sense inputs are asynchronous pins; samples on clk domain
// Notes: register access is the serial control port only
// What this block does
// - fault register bits 7:6 read zero; host writes them as zero.
// - overcurrent scale field bits 5:4, reset 00, trip at 100/75/50/25 percent.
// - clock fault flag bit 3 follows the live fault, never latches.
// - overcurrent flag bit 2 latches, halts operation until shutdown toggles.
// - output DC flag bit 1 latches until shutdown toggles.
// - overtemperature flag bit 0 latches, blocks operation until shutdown toggles.
// - clip threshold is 20 bits; register 0x10 holds bits 13:6.
// - register 0x11 bits 7:2 hold threshold bits 5:0; bits 1:0 reserved.
`timescale 1ns/1ps
`default_nettype none
module afc_fault_clip
    import afc_pkg::*;
(
    input wire logic clk, // 50 MHz system clock
    input wire logic rst, // async reset, active high
    input wire logic [6:0] dev_addr, // control-port target address
    input wire logic scl, // control-port clock pin
    input wire logic sda_i, // control-port data level
    output logic sda_o, // data drive value (always low)
    output logic sda_oe_n, // data drive enable, low drives
    input wire logic amp_shutdown_n, // shutdown pin, low = shut down
    input wire logic clock_fault_in, // clock monitor fault level
    input wire logic [SENSE_W-1:0] current_sense, // output current code
    input wire logic dc_fault_in, // output DC detector level
    input wire logic temp_fault_in, // die overtemperature level
    input wire logic signed [SAMPLE_W-1:0] sample_in, // audio sample
    input wire logic sample_in_valid, // sample strobe
    output logic signed [SAMPLE_W-1:0] sample_out, // clipped sample
    output logic sample_out_valid, // clipped sample strobe
    output logic amp_run // power stage enable
);
    logic [7:0] ptr, wr_data, rd_data;
    logic wr_stb;
    logic [1:0] sd_s, clk_s, dc_s, ot_s;
    logic [SENSE_W-1:0] cur_s0, cur_s1, cur_s2;
    logic sd_q;
    logic [1:0] oc_scale, next_oc_scale;
    logic clk_flag, oc_flag, dc_flag, ot_flag;
    logic next_clk_flag, next_oc_flag, next_dc_flag, next_ot_flag;
    logic [7:0] clip_mid, next_clip_mid, clip_low, next_clip_low;
    logic [7:0] clip_high, next_clip_high;
    logic [SENSE_W-1:0] trip, quarter;
    logic oc_now, sd_release, next_amp_run;
    logic [CLIP_W-1:0] clip_threshold_value;
    logic signed [SAMPLE_W-1:0] pos_lim, neg_lim, next_sample_out;
    logic next_sample_out_valid;

    afc_ctrl_port u_port (
        .clk(clk),
        .rst(rst),
        .dev_addr(dev_addr),
        .scl(scl),
        .sda_i(sda_i),
        .sda_o(sda_o),
        .sda_oe_n(sda_oe_n),
        .ptr(ptr),
        .wr_stb(wr_stb),
        .wr_data(wr_data),
        .rd_data(rd_data)
    );

    // trip = nominal minus one quarter per scale step
    assign quarter = OC_TRIP_NOM >> 2;
    always_comb begin
        case (oc_scale)
            2'h0: trip = OC_TRIP_NOM;
            2'h1: trip = OC_TRIP_NOM - quarter;
            2'h2: trip = OC_TRIP_NOM - (quarter << 1);
            default: trip = quarter;
        endcase
    end
    // a code caught mid-change is ignored until two samples agree
    assign oc_now = (cur_s2 > trip) && (cur_s1 == cur_s2);
    // release edge of the shutdown pin is the one-cycle clear pulse
    assign sd_release = sd_s[1] & ~sd_q;

    assign clip_threshold_value = {clip_high[HIGH_FIELD_W-1:0], clip_mid,
        clip_low[7:LOW_FIELD_LO]};

    always_comb begin
        rd_data = 8'h00;
        case (ptr)
            REG_FAULT: begin
                rd_data[SCALE_HI:SCALE_LO] = oc_scale;
                rd_data[BIT_CLK] = clk_flag;
                rd_data[BIT_OC] = oc_flag;
                rd_data[BIT_DC] = dc_flag;
                rd_data[BIT_OT] = ot_flag;
            end
            REG_CLIP_MID: rd_data = clip_mid;
            REG_CLIP_LOW: rd_data = clip_low;
            REG_CLIP_HIGH: rd_data = {2'h0, clip_high[HIGH_FIELD_W-1:0]};
            default: rd_data = 8'h00;
        endcase
    end

    always_comb begin
        next_oc_scale = oc_scale;
        next_clip_mid = clip_mid;
        next_clip_low = clip_low;
        next_clip_high = clip_high;
        // writes are taken at any time; the host keeps to shutdown windows
        if (wr_stb) begin
            case (ptr)
                REG_FAULT: next_oc_scale = wr_data[SCALE_HI:SCALE_LO];
                REG_CLIP_MID: next_clip_mid = wr_data;
                REG_CLIP_LOW: next_clip_low = wr_data;
                REG_CLIP_HIGH: next_clip_high = {2'h0, wr_data[HIGH_FIELD_W-1:0]};
                default: next_oc_scale = oc_scale;
            endcase
        end
    end

    always_comb begin
        next_clk_flag = clk_s[1];
        // a live fault wins over the clear on the release edge
        next_oc_flag = oc_now | (oc_flag & ~sd_release);
        next_dc_flag = dc_s[1] | (dc_flag & ~sd_release);
        next_ot_flag = ot_s[1] | (ot_flag & ~sd_release);
        next_amp_run = sd_s[1] & ~clk_s[1] & ~next_oc_flag
            & ~next_dc_flag & ~next_ot_flag;
    end

    assign pos_lim = SAMPLE_W'(clip_threshold_value);
    assign neg_lim = -pos_lim;
    always_comb begin
        next_sample_out = sample_out;
        next_sample_out_valid = sample_in_valid;
        if (sample_in_valid) begin
            if (sample_in > pos_lim) begin
                next_sample_out = pos_lim;
            end else if (sample_in < neg_lim) begin
                next_sample_out = neg_lim;
            end else begin
                next_sample_out = sample_in;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sd_s <= 2'h0;
            clk_s <= 2'h0;
            dc_s <= 2'h0;
            ot_s <= 2'h0;
            cur_s0 <= '0;
            cur_s1 <= '0;
            cur_s2 <= '0;
            sd_q <= 1'b0;
            oc_scale <= SCALE_RST;
            clk_flag <= 1'b0;
            oc_flag <= 1'b0;
            dc_flag <= 1'b0;
            ot_flag <= 1'b0;
            clip_mid <= CLIP_MID_RST;
            clip_low <= CLIP_LOW_RST;
            clip_high <= CLIP_HIGH_RST;
            amp_run <= 1'b0;
            sample_out <= '0;
            sample_out_valid <= 1'b0;
        end else begin
            sd_s <= {sd_s[0], amp_shutdown_n};
            clk_s <= {clk_s[0], clock_fault_in};
            dc_s <= {dc_s[0], dc_fault_in};
            ot_s <= {ot_s[0], temp_fault_in};
            // sense code is a slow analog level; settles well inside two cycles
            cur_s0 <= current_sense;
            cur_s1 <= cur_s0;
            cur_s2 <= cur_s1;
            sd_q <= sd_s[1];
            oc_scale <= next_oc_scale;
            clk_flag <= next_clk_flag;
            oc_flag <= next_oc_flag;
            dc_flag <= next_dc_flag;
            ot_flag <= next_ot_flag;
            clip_mid <= next_clip_mid;
            clip_low <= next_clip_low;
            clip_high <= next_clip_high;
            amp_run <= next_amp_run;
            sample_out <= next_sample_out;
            sample_out_valid <= next_sample_out_valid;
        end
    end
endmodule
`default_nettype wire

// >>> dv/afc_fault_clip_props.sv
// Purpose: port-level checks for the fault/clipper register slice
// Assumes: one clk domain, rst async active high
// Notes: fault windows are long enough to clear the input synchronisers
`timescale 1ns/1ps
`default_nettype none
module afc_fault_clip_props
    import afc_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic rst, // async reset
    input wire logic amp_shutdown_n, // shutdown pin
    input wire logic clock_fault_in, // clock fault level
    input wire logic [SENSE_W-1:0] current_sense, // current code
    input wire logic dc_fault_in, // dc fault level
    input wire logic temp_fault_in, // overtemp level
    input wire logic signed [SAMPLE_W-1:0] sample_in, // sample
    input wire logic sample_in_valid, // sample strobe
    input wire logic signed [SAMPLE_W-1:0] sample_out, // clipped sample
    input wire logic sample_out_valid, // clipped strobe
    input wire logic amp_run // power stage enable
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // cause gone but shutdown never toggled, so a latch must hold
    sequence s_quiet;
        (amp_shutdown_n && !temp_fault_in && !dc_fault_in && current_sense == 8'h00) [*8];
    endsequence
    sequence s_overcurrent;
        (amp_shutdown_n && current_sense > 8'hC0) [*4];
    endsequence
    a_ot_latch_hold: assert property ((amp_shutdown_n && temp_fault_in) [*4] ##1 s_quiet |-> !amp_run)
        else $error("overtemp fault did not hold the stage off");
    a_dc_latch_hold: assert property ((amp_shutdown_n && dc_fault_in) [*4] ##1 s_quiet |-> !amp_run)
        else $error("output dc fault did not hold the stage off");
    a_oc_latch_hold: assert property (s_overcurrent ##1 s_quiet |-> !amp_run)
        else $error("overcurrent fault did not hold the stage off");
    a_clk_fault_stop: assert property (clock_fault_in [*4] |=> !amp_run)
        else $error("stage ran during a clock fault");
    a_shutdown_stop: assert property (!amp_shutdown_n [*4] |=> !amp_run)
        else $error("stage ran while shut down");
    a_sample_lag_one: assert property (sample_in_valid |=> sample_out_valid)
        else $error("clipped sample strobe missing");
    a_no_stray_valid: assert property (sample_out_valid |-> $past(sample_in_valid))
        else $error("clipped sample strobe without input");
    a_out_hold_idle: assert property (!sample_out_valid |-> $stable(sample_out))
        else $error("clipped sample changed between strobes");
    a_clip_bound_max: assert property (sample_out_valid |-> sample_out <= 24'sh0FFFFF && sample_out >= -24'sh0FFFFF)
        else $error("clipped sample beyond the 20-bit range");
    a_zero_pass_thru: assert property (sample_in_valid && sample_in == '0 |=> sample_out == '0)
        else $error("zero sample altered");
endmodule
bind afc_fault_clip afc_fault_clip_props u_props (
    .clk(clk), .rst(rst), .amp_shutdown_n(amp_shutdown_n), .clock_fault_in(clock_fault_in),
    .current_sense(current_sense), .dc_fault_in(dc_fault_in), .temp_fault_in(temp_fault_in),
    .sample_in(sample_in), .sample_in_valid(sample_in_valid), .sample_out(sample_out),
    .sample_out_valid(sample_out_valid), .amp_run(amp_run)
);
`default_nettype wire

// >>> dv/afc_host_model.sv
// Purpose: host processor model driving the two-wire control port
// Assumes: open-drain data line with pull-up resolved by the bench
// Notes: scl phases of 5-6 clk keep above the 4 clk sampling floor
`timescale 1ns/1ps
`default_nettype none
module afc_host_model
    import afc_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic sda, // resolved data line
    output logic scl, // serial clock, stands high when idle
    output logic sda_pull // high pulls data low
);
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic line(input logic p, input logic c, input int n);
        sda_pull = p;
        scl = c;
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic put(input logic b, output logic r);
        line(!b, 1'b0, 4);
        line(!b, 1'b1, 5);
        r = sda;
        line(!b, 1'b0, 2);
    endtask
    task automatic start();
        line(1'b0, 1'b0, 4);
        line(1'b0, 1'b1, 5);
        line(1'b1, 1'b1, 5);
        line(1'b1, 1'b0, 2);
    endtask
    task automatic stop();
        line(1'b1, 1'b0, 4);
        line(1'b1, 1'b1, 5);
        line(1'b0, 1'b1, 5);
    endtask
    task automatic send(input logic [7:0] d, output logic nack);
        logic r;
        for (int i = 7; i >= 0; i--) put(d[i], r);
        put(1'b1, nack);
    endtask
    function automatic logic rsvd(input logic [7:0] a);
        return a == REG_RSVD_A || (a >= REG_RSVD_LO && a <= REG_RSVD_HI);
    endfunction
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic nack);
        logic [2:0] n;
        logic [7:0] v;
        v = (a == REG_FAULT) ? (d & 8'h3F) : d;
        if (a == REG_CLIP_LOW) v = d & 8'hFC;
        n = 3'h7;
        if (!rsvd(a)) begin
            start();
            send({DEV_ADDR_DEFAULT, 1'b0}, n[2]);
            send(a, n[1]);
            send(v, n[0]);
            stop();
        end
        nack = |n;
    endtask
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic nack);
        logic [2:0] n;
        logic r;
        n = 3'h7;
        d = 8'h00;
        if (!rsvd(a)) begin
            start();
            send({DEV_ADDR_DEFAULT, 1'b0}, n[2]);
            send(a, n[1]);
            start();
            send({DEV_ADDR_DEFAULT, 1'b1}, n[0]);
            for (int i = 7; i >= 0; i--) put(1'b1, d[i]);
            put(1'b1, r);
            stop();
        end
        nack = |n;
    endtask
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
// Purpose: self-checking bench for the fault/clipper register slice
// Assumes: host model owns the control port; bench drives pins 1 ns after clk
// Notes: register and clip model kept here, written apart from the design
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import afc_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic scl, sda_pull, sda_o, sda_oe_n, sda, amp_run, sample_out_valid, nack;
    logic amp_shutdown_n = 1'b0;
    logic clock_fault_in = 1'b0;
    logic dc_fault_in = 1'b0;
    logic temp_fault_in = 1'b0;
    logic sample_in_valid = 1'b0;
    logic [7:0] current_sense = 8'h00;
    logic [7:0] trip, rd;
    logic signed [23:0] sample_in = 24'h000000;
    logic signed [23:0] sample_out;
    logic [31:0] lfsr_st = 32'h0515;
    logic [7:0] mem [0:255];
    logic [7:0] rd_list [5] = '{REG_FAULT, REG_CLIP_MID, REG_CLIP_LOW, REG_CLIP_HIGH, 8'h13};
    logic [1:0] scale_m = 2'h0;
    logic [3:0] flags_m = 4'h0;
    int fbit [4] = '{BIT_CLK, BIT_DC, BIT_OT, BIT_OC};
    int errors = 0;
    int checks = 0;
    int thr, smp, exp_s;
    always #10 clk = ~clk;
    assign sda = !(sda_pull || (!sda_oe_n && !sda_o)); // pull-up wins unless someone pulls
    afc_fault_clip u_afc_fault_clip (.clk(clk), .rst(rst), .dev_addr(DEV_ADDR_DEFAULT), .scl(scl),
        .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .amp_shutdown_n(amp_shutdown_n),
        .clock_fault_in(clock_fault_in), .current_sense(current_sense), .dc_fault_in(dc_fault_in),
        .temp_fault_in(temp_fault_in), .sample_in(sample_in), .sample_in_valid(sample_in_valid),
        .sample_out(sample_out), .sample_out_valid(sample_out_valid), .amp_run(amp_run));
    afc_host_model u_afc_host_model (.clk(clk), .sda(sda), .scl(scl), .sda_pull(sda_pull));
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic rdchk(input logic [7:0] a);
        u_afc_host_model.read_reg(a, rd, nack);
        cmp(32'(nack), 0);
        cmp(32'(rd), (a == REG_FAULT) ? 32'({2'b00, scale_m, flags_m}) : 32'(mem[a]));
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_afc_host_model.write_reg(a, d, nack);
        cmp(32'(nack), 0);
        if (a == REG_FAULT) scale_m = d[5:4];
        else mem[a] = d;
    endtask
    task automatic set_fault(input int k, input logic on);
        case (k)
            0: clock_fault_in = on;
            1: dc_fault_in = on;
            2: temp_fault_in = on;
            default: current_sense = on ? trip + 8'h01 : 8'h00;
        endcase
        if (on) flags_m[fbit[k]] = 1'b1;
    endtask
    task automatic toggle();
        amp_shutdown_n = 1'b0;
        tick(8);
        amp_shutdown_n = 1'b1;
        tick(8);
    endtask
    task automatic fault_run(input int k, input logic [1:0] s);
        amp_shutdown_n = 1'b0;
        wr(REG_FAULT, {2'b00, s, 4'h0});
        amp_shutdown_n = 1'b1;
        trip = 8'hC0 - 8'h30 * s;
        current_sense = trip; // equal to the trip level must not fault
        tick(8);
        cmp(32'(amp_run), 1);
        set_fault(k, 1'b1);
        tick(8);
        cmp(32'(amp_run), 0);
        rdchk(REG_FAULT);
        if (k != 0) begin
            toggle();
            rdchk(REG_FAULT);
            set_fault(k, 1'b0);
            rdchk(REG_FAULT);
            toggle();
        end
        set_fault(k, 1'b0);
        flags_m = 4'h0;
        tick(8);
        cmp(32'(amp_run), 1);
        rdchk(REG_FAULT);
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 8'h00;
        mem[REG_CLIP_MID] = CLIP_MID_RST;
        mem[REG_CLIP_LOW] = CLIP_LOW_RST;
        tick(20);
        rst = 1'b0;
        tick(4);
        for (int i = 0; i < 5; i++) rdchk(rd_list[i]);
        wr(REG_FAULT, 8'h3F);
        rdchk(REG_FAULT);
        for (int r = 0; r < 3; r++) begin
            lfsr_st = lfsr_next(lfsr_st);
            wr(REG_CLIP_MID, lfsr_st[7:0]);
            wr(REG_CLIP_LOW, {lfsr_st[13:8], 2'b00});
            wr(REG_CLIP_HIGH, {2'b00, lfsr_st[19:14]});
            for (int i = 1; i < 4; i++) rdchk(rd_list[i]);
            thr = int'({mem[REG_CLIP_HIGH][5:0], mem[REG_CLIP_MID], mem[REG_CLIP_LOW][7:2]});
            for (int i = 0; i < 8; i++) begin
                lfsr_st = lfsr_next(lfsr_st);
                case (i % 4)
                    0: smp = thr;
                    1: smp = thr + 1;
                    2: smp = -thr - 1;
                    default: smp = int'($signed(lfsr_st[23:0]));
                endcase
                sample_in = smp[23:0];
                sample_in_valid = 1'b1;
                tick(1);
                exp_s = (smp > thr) ? thr : ((smp < -thr) ? -thr : smp);
                cmp(32'(sample_out_valid), 1);
                cmp({8'h00, sample_out}, {8'h00, exp_s[23:0]});
            end
            sample_in_valid = 1'b0;
        end
        for (int k = 0; k < 3; k++) fault_run(k, 2'(k));
        for (int s = 0; s < 4; s++) fault_run(3, 2'(s));
        complete_run();
    end
    initial begin
        #1500000;
        errors++;
        complete_run();
    end
endmodule
`default_nettype wire
